// ==== rtl/dbc_map.vh ====
// Display blanking controller: register offsets, fields, reset values, timing.
// Included by the blanking controller and its tick generator; definitions only.
`ifndef DBC_MAP_VH
`define DBC_MAP_VH

// Register byte offsets on the APB bus
`define DBC_CTRL_OFS        12'h000
`define DBC_STAT_OFS        12'h004

// Control register fields
`define DBC_DELAY_LSB       0
`define DBC_DELAY_MSB       2
`define DBC_SELECT_LSB      4
`define DBC_SELECT_MSB      7
`define DBC_CTRL_RST        32'h0000_0000
`define DBC_DELAY_RST       3'h0
`define DBC_SELECT_RST      4'h0

// Status register fields
`define DBC_ST_AUTO_BIT     0
`define DBC_ST_RELIGHT_BIT  1
`define DBC_ST_INERR_BIT    2
`define DBC_ST_ALARM_BIT    3
`define DBC_ST_PVD_BIT      4
`define DBC_ST_SVD_BIT      5
`define DBC_ST_LAMP_BIT     6
`define DBC_ST_SVL_BIT      7
`define DBC_ST_PVL_BIT      8
`define DBC_ST_IDLE_LSB     16

// Automatic blanking delay codes
`define DBC_DLY_OFF         3'h0
`define DBC_DLY_15S         3'h1
`define DBC_DLY_30S         3'h2
`define DBC_DLY_1M          3'h3
`define DBC_DLY_5M          3'h4

// Idle times in seconds for each delay code
`define DBC_IDLE_15S        9'h00F
`define DBC_IDLE_30S        9'h01E
`define DBC_IDLE_1M         9'h03C
`define DBC_IDLE_5M         9'h12C

// Manual selector: first value that relights on a key press, and its window
`define DBC_SEL_RELIGHT     4'h5
`define DBC_RELIGHT_SEC     3'h5

// Time base: one tick per second at the system clock rate
`define DBC_TICK_MS         1000
`define DBC_CLK_KHZ         25000
`define DBC_TICK_CYCLES     (`DBC_TICK_MS * `DBC_CLK_KHZ)

`endif

// ==== rtl/dbc_tick_gen.v ====
// One-second tick and half-second blink phase for the blanking controller.
// Assumes a free-running system clock; restart_i realigns the second boundary.
`timescale 1ns/1ps
`include "dbc_map.vh"

module dbc_tick_gen #(
   parameter integer TICK_CYCLES = `DBC_TICK_CYCLES
) (
   // Clock and reset
   input  wire        sys_clk_i,
   input  wire        arst_n_i,
   // Control
   input  wire        restart_i,
   // Time base
   output reg         tick_o,
   output reg         blink_o
);

   localparam integer HALF_CYCLES = (TICK_CYCLES / 2 > 0) ? TICK_CYCLES / 2 : 1;

   reg  [31:0]  cnt_q;

   // Cycle counter, one pulse at each full second, blink toggles each half
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q   <= 32'h0000_0000;
         tick_o  <= 1'b0;
         blink_o <= 1'b0;
      end else if (restart_i) begin
         cnt_q   <= 32'h0000_0000;
         tick_o  <= 1'b0;
         blink_o <= 1'b0;
      end else if (cnt_q == TICK_CYCLES - 1) begin
         cnt_q   <= 32'h0000_0000;
         tick_o  <= 1'b1;
         blink_o <= 1'b0;
      end else begin
         cnt_q   <= cnt_q + 32'h0000_0001;
         tick_o  <= 1'b0;
         if (cnt_q == HALF_CYCLES - 1) begin
            blink_o <= 1'b1;
         end
      end
   end

endmodule // dbc_tick_gen

// ==== rtl/dbc_blank_ctrl.v ====
// Front-panel display blanking controller with an APB register port.
// Assumes key, alarm and input-error levels arrive asynchronously from pins.
//
// How it works
// - 15 s or 30 s idle blanks displays
// - 1 min or 5 min idle blanks; off never
// - auto blank: all dark, setpoint lamp on, value lamp blinks, unless the selector blanks the lamps
// - no auto blanking during input error or alarm
// - error or alarm relights both displays at once
// - selector 0 to 4 picks blanked items
// - selector 5 to 8 relight five seconds per key
// - error or alarm keeps relit items on
// - input error is over, under or fault
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "dbc_map.vh"

module dbc_blank_ctrl #(
   parameter integer TICK_CYCLES = `DBC_TICK_CYCLES
) (
   // Clock and reset
   input  wire        sys_clk_i,
   input  wire        arst_n_i,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   // Keypad and measurement status pins
   input  wire        key_press_i,
   input  wire        alarm_i,
   input  wire        in_over_i,
   input  wire        in_under_i,
   input  wire        in_fault_i,
   // Display and lamp drivers
   output reg         pv_disp_on_o,
   output reg         sv_disp_on_o,
   output reg         lamps_on_o,
   output reg         sv_lamp_on_o,
   output reg         pv_lamp_on_o
);

   // Decode selector into {lamps off, process value off, setpoint off}
   function [2:0] dbc_sel_mask;
      input [3:0] sel;
      begin
         case (sel)
            4'h1, 4'h5: dbc_sel_mask = 3'h1;
            4'h2, 4'h6: dbc_sel_mask = 3'h2;
            4'h3, 4'h7: dbc_sel_mask = 3'h3;
            4'h4, 4'h8: dbc_sel_mask = 3'h7;
            default:    dbc_sel_mask = 3'h0;
         endcase
      end
   endfunction

   // Idle seconds for a delay code; zero means never
   function [8:0] dbc_idle_limit;
      input [2:0] code;
      begin
         case (code)
            `DBC_DLY_15S: dbc_idle_limit = `DBC_IDLE_15S;
            `DBC_DLY_30S: dbc_idle_limit = `DBC_IDLE_30S;
            `DBC_DLY_1M:  dbc_idle_limit = `DBC_IDLE_1M;
            `DBC_DLY_5M:  dbc_idle_limit = `DBC_IDLE_5M;
            default:      dbc_idle_limit = 9'h000;
         endcase
      end
   endfunction

   // Register decode: bit 0 control word, bit 1 status word, none otherwise
   function [1:0] dbc_reg_hit;
      input [11:0] addr;
      begin
         if (addr == `DBC_CTRL_OFS) begin
            dbc_reg_hit = 2'h1;
         end else if (addr == `DBC_STAT_OFS) begin
            dbc_reg_hit = 2'h2;
         end else begin
            dbc_reg_hit = 2'h0;
         end
      end
   endfunction

   reg  [2:0]  auto_blank_delay_q;
   reg  [3:0]  manual_blank_select_q;
   reg  [4:0]  sync1_q;
   reg  [4:0]  sync2_q;
   reg         key_prev_q;
   reg  [8:0]  idle_cnt_q;
   reg         auto_blank_q;
   reg  [2:0]  relight_cnt_q;
   reg         relight_q;
   reg  [2:0]  off_mask;
   reg         pv_disp_d;
   reg         sv_disp_d;
   reg         lamps_d;
   reg         sv_lamp_d;
   reg         pv_lamp_d;

   wire        key_lvl;
   wire        key_pulse;
   wire        in_error;
   wire        alarm_lvl;
   wire        fault_any;
   wire        tick;
   wire        blink;
   wire [8:0]  idle_limit;
   wire        relight_mode;
   wire [2:0]  man_mask;
   wire [1:0]  reg_hit;
   wire        wr_en;
   wire        rd_setup;
   wire        addr_ok;

   // Two-stage synchronisers for all pin inputs
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= {in_fault_i, in_under_i, in_over_i, alarm_i, key_press_i};
         sync2_q <= sync1_q;
      end
   end

   assign key_lvl   = sync2_q[0];
   assign alarm_lvl = sync2_q[1];
   assign in_error  = sync2_q[2] | sync2_q[3] | sync2_q[4];
   assign fault_any = in_error | alarm_lvl;

   // Rising edge of the synchronised key level
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         key_prev_q <= 1'b0;
      end else begin
         key_prev_q <= key_lvl;
      end
   end

   assign key_pulse = key_lvl & ~key_prev_q;

   dbc_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .sys_clk_i   (sys_clk_i),
      .arst_n_i    (arst_n_i),
      .restart_i   (key_pulse),
      .tick_o      (tick),
      .blink_o     (blink)
   );

   // APB decode; zero wait states, unmapped addresses flag an error
   assign pready   = 1'b1;
   assign reg_hit  = dbc_reg_hit(paddr);
   assign addr_ok  = |reg_hit;
   assign pslverr  = psel & penable & ~addr_ok;
   assign wr_en    = psel & penable & pwrite & reg_hit[0];
   assign rd_setup = psel & ~penable & ~pwrite;

   // Control register written by software
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         auto_blank_delay_q    <= `DBC_DELAY_RST;
         manual_blank_select_q <= `DBC_SELECT_RST;
      end else if (wr_en) begin
         auto_blank_delay_q    <= pwdata[`DBC_DELAY_MSB:`DBC_DELAY_LSB];
         manual_blank_select_q <= pwdata[`DBC_SELECT_MSB:`DBC_SELECT_LSB];
      end
   end

   // Read data captured in the setup phase so it is stable in the access phase
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         if (reg_hit[0]) begin
            prdata <= 32'h0000_0000;
            prdata[`DBC_DELAY_MSB:`DBC_DELAY_LSB]   <= auto_blank_delay_q;
            prdata[`DBC_SELECT_MSB:`DBC_SELECT_LSB] <= manual_blank_select_q;
         end else if (reg_hit[1]) begin
            prdata <= 32'h0000_0000;
            prdata[`DBC_ST_AUTO_BIT]    <= auto_blank_q;
            prdata[`DBC_ST_RELIGHT_BIT] <= relight_q;
            prdata[`DBC_ST_INERR_BIT]   <= in_error;
            prdata[`DBC_ST_ALARM_BIT]   <= alarm_lvl;
            prdata[`DBC_ST_PVD_BIT]     <= pv_disp_on_o;
            prdata[`DBC_ST_SVD_BIT]     <= sv_disp_on_o;
            prdata[`DBC_ST_LAMP_BIT]    <= lamps_on_o;
            prdata[`DBC_ST_SVL_BIT]     <= sv_lamp_on_o;
            prdata[`DBC_ST_PVL_BIT]     <= pv_lamp_on_o;
            prdata[`DBC_ST_IDLE_LSB+8:`DBC_ST_IDLE_LSB] <= idle_cnt_q;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   assign idle_limit = dbc_idle_limit(auto_blank_delay_q);

   // Idle timer and automatic blanking state
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         idle_cnt_q   <= 9'h000;
         auto_blank_q <= 1'b0;
      end else if (key_pulse) begin
         idle_cnt_q   <= 9'h000;
         auto_blank_q <= 1'b0;
      end else if (fault_any || idle_limit == 9'h000) begin
         idle_cnt_q   <= 9'h000;
         auto_blank_q <= 1'b0;
      end else if (tick && !auto_blank_q) begin
         if (idle_cnt_q + 9'h001 >= idle_limit) begin
            idle_cnt_q   <= idle_limit;
            auto_blank_q <= 1'b1;
         end else begin
            idle_cnt_q   <= idle_cnt_q + 9'h001;
         end
      end
   end

   assign relight_mode = (manual_blank_select_q >= `DBC_SEL_RELIGHT);

   // Five-second relight window for selector values 5 to 8
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         relight_cnt_q <= 3'h0;
         relight_q     <= 1'b0;
      end else if (key_pulse && relight_mode) begin
         relight_cnt_q <= 3'h0;
         relight_q     <= 1'b1;
      end else if (!relight_mode) begin
         relight_cnt_q <= 3'h0;
         relight_q     <= 1'b0;
      end else if (relight_q && tick) begin
         if (relight_cnt_q + 3'h1 >= `DBC_RELIGHT_SEC) begin
            relight_cnt_q <= `DBC_RELIGHT_SEC;
            relight_q     <= fault_any;
         end else begin
            relight_cnt_q <= relight_cnt_q + 3'h1;
         end
      end else if (relight_q && relight_cnt_q == `DBC_RELIGHT_SEC) begin
         relight_q <= fault_any;
      end
   end

   assign man_mask = dbc_sel_mask(manual_blank_select_q);

   // relit or faulted modes 5 to 8 show everything
   always @* begin
      if (relight_mode && (relight_q || fault_any)) begin
         off_mask = 3'h0;
      end else if (fault_any) begin
         off_mask = man_mask & 3'h4;
      end else begin
         off_mask = man_mask;
      end
   end

   // Next panel state; automatic blanking overrides the manual display masks, not the lamp mask
   always @* begin
      if (auto_blank_q) begin
         pv_disp_d = 1'b0;
         sv_disp_d = 1'b0;
         lamps_d   = 1'b0;
         sv_lamp_d = ~off_mask[2];
         pv_lamp_d = blink & ~off_mask[2];
      end else begin
         pv_disp_d = ~off_mask[1];
         sv_disp_d = ~off_mask[0];
         lamps_d   = ~off_mask[2];
         sv_lamp_d = ~off_mask[2];
         pv_lamp_d = ~off_mask[2];
      end
   end

   // Registered display and lamp drive, lit out of reset
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pv_disp_on_o <= 1'b1;
         sv_disp_on_o <= 1'b1;
         lamps_on_o   <= 1'b1;
         sv_lamp_on_o <= 1'b1;
         pv_lamp_on_o <= 1'b1;
      end else begin
         pv_disp_on_o <= pv_disp_d;
         sv_disp_on_o <= sv_disp_d;
         lamps_on_o   <= lamps_d;
         sv_lamp_on_o <= sv_lamp_d;
         pv_lamp_on_o <= pv_lamp_d;
      end
   end

endmodule // dbc_blank_ctrl

// ==== verif/dbc_blank_props.sv ====
// Checks on the blanking controller's bus and panel outputs.
// Assumes one clock and the block's asynchronous active-low reset.
`timescale 1ns/1ps

module dbc_blank_props (
   // Clock and reset
   input wire        sys_clk_i,
   input wire        arst_n_i,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pslverr,
   input wire [31:0] prdata,
   // Panel
   input wire        key_press_i,
   input wire        alarm_i,
   input wire        in_over_i,
   input wire        in_under_i,
   input wire        in_fault_i,
   input wire        pv_disp_on_o,
   input wire        sv_disp_on_o,
   input wire        lamps_on_o,
   input wire        sv_lamp_on_o
);
   wire       err_w = alarm_i | in_over_i | in_under_i | in_fault_i;
   wire       acc_w = psel & penable;
   wire       map_w = (paddr == 12'h000) | (paddr == 12'h004);
   wire       on_w  = pv_disp_on_o & sv_disp_on_o;
   reg  [7:0] ctrl_q;
   wire [3:0] sel_w = ctrl_q[7:4];
   // Shadow of the control word as software wrote it
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         ctrl_q <= 8'h00;
      else if (acc_w && pwrite && paddr == 12'h000)
         ctrl_q <= pwdata[7:0];
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Key edge after the pin synchronizer
   sequence key_s;
      $rose(key_press_i) ##3 1'b1;
   endsequence
   // Settled selector, no fault, for eight cycles
   sequence quiet_s;
      (!err_w && $stable(ctrl_q))[*8];
   endsequence
   a_bad_addr_err: assert property (acc_w && !map_w |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_good_addr_ok: assert property (acc_w && map_w |-> !pslverr)
      else $error("mapped access flagged");
   a_ctrl_readback: assert property (acc_w && !pwrite && paddr == 12'h000 |-> // fields
      prdata[7:4] == sel_w && prdata[2:0] == ctrl_q[2:0])
      else $error("control readback wrong");
   a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved");
   a_err_relight: assert property (err_w [*6] |-> on_w) // fault lit
      else $error("displays dark during fault");
   a_auto_dark: assert property ((!err_w)[*6] ##0 (sv_lamp_on_o && !lamps_on_o) |-> // shape
      !pv_disp_on_o && !sv_disp_on_o)
      else $error("blank pattern wrong");
   a_key_relight: assert property (key_s ##0 (!err_w && (sel_w == 0 || // key
      (sel_w > 4 && sel_w < 9))) |-> ##[0:3] on_w)
      else $error("key did not relight");
   a_manual_mask: assert property (quiet_s ##0 (sel_w > 0 && sel_w < 5) |-> // masks
      !(sv_disp_on_o && sel_w != 2) && !(pv_disp_on_o && sel_w != 1) &&
      !(lamps_on_o && sel_w == 4))
      else $error("manual blank mask wrong");
endmodule // dbc_blank_props

bind dbc_blank_ctrl dbc_blank_props u_props (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pslverr(pslverr), .prdata(prdata), .key_press_i(key_press_i), .alarm_i(alarm_i),
   .in_over_i(in_over_i), .in_under_i(in_under_i), .in_fault_i(in_fault_i),
   .pv_disp_on_o(pv_disp_on_o), .sv_disp_on_o(sv_disp_on_o), .lamps_on_o(lamps_on_o),
   .sv_lamp_on_o(sv_lamp_on_o));

// ==== verif/dbc_panel_model.sv ====
// Keypad and lamp-driver stand-in for the panel side.
// Assumes the bench asks for presses; counts value-lamp changes.
`timescale 1ns/1ps

module dbc_panel_model (
   // Clock
   input  wire       sys_clk_i,
   // Panel lines
   input  wire       pv_lamp_i,
   output reg        key_o,
   output reg  [7:0] blinks_o
);
   reg last_q = 1'b1;
   initial begin
      key_o = 1'b0;
      blinks_o = 8'h00;
   end
   // Count each change of the value lamp
   always @(posedge sys_clk_i) begin
      last_q <= pv_lamp_i;
      if (last_q !== pv_lamp_i)
         blinks_o <= blinks_o + 8'h01;
   end
   // Contact closes for len cycles, open at rest
   task automatic press(input int len);
      @(posedge sys_clk_i);
      key_o <= 1'b1;
      repeat (len) @(posedge sys_clk_i);
      key_o <= 1'b0;
   endtask
endmodule // dbc_panel_model

// ==== verif/testbench.sv ====
// Bench for the blanking controller: APB driver, panel stimulus, queued checks.
// Assumes the checker is bound and the tick is cut to TICK cycles.
`timescale 1ns/1ps

module testbench;
   localparam int TICK = 20;
   typedef struct {string nm; logic [31:0] exp; logic [31:0] msk; bit rd;} dbc_note_t;
   dbc_note_t   note_q[$];
   dbc_note_t   n_m;
   logic        sys_clk_i, arst_n_i, psel, penable, pwrite;
   logic        alarm_i, in_over_i, in_under_i, in_fault_i;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd_q, seen;
   logic [7:0]  b0;
   wire         pready, pslverr, key_w;
   wire  [31:0] prdata;
   wire  [4:0]  disp_w;
   wire  [7:0]  blinks;
   int          num_errors, checks, cyc, seed, s;
   int          dly[4] = '{15, 30, 60, 300};
   logic [4:0]  sel_exp[9] = '{5'h1F, 5'h17, 5'h0F, 5'h07, 5'h00, 5'h17, 5'h0F, 5'h07, 5'h00};
   event        look_ev;

   dbc_blank_ctrl #(.TICK_CYCLES(TICK)) u_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .key_press_i(key_w),
      .alarm_i(alarm_i), .in_over_i(in_over_i), .in_under_i(in_under_i),
      .in_fault_i(in_fault_i), .pv_disp_on_o(disp_w[4]), .sv_disp_on_o(disp_w[3]),
      .lamps_on_o(disp_w[2]), .sv_lamp_on_o(disp_w[1]), .pv_lamp_on_o(disp_w[0]));
   dbc_panel_model u_panel (.sys_clk_i(sys_clk_i), .pv_lamp_i(disp_w[0]), .key_o(key_w),
      .blinks_o(blinks));

   // 25 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   // Cut a hang short
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors++;
         results();
      end
   end
   // Take the oldest note when a result is ready and compare
   initial begin
      forever begin
         @(look_ev);
         #1;
         n_m = note_q.pop_front();
         seen = n_m.rd ? rd_q : {27'h0, disp_w};
         checks++;
         if ((seen & n_m.msk) !== (n_m.exp & n_m.msk)) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n_m.nm, n_m.exp & n_m.msk, seen & n_m.msk);
         end
      end
   end

   task automatic note(input string nm, input logic [31:0] exp, msk, input bit rd);
      note_q.push_back('{nm, exp, msk, rd});
      -> look_ev;
   endtask
   // One APB transfer; keeps read data or the error flag of a write
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk_i);
      end while (pready !== 1'b1);
      rd_q = w ? {31'h0, pslverr} : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic push_key;
      u_panel.press(1 + $unsigned($random(seed)) % 8);
   endtask
   task automatic secs(input int n, input int extra);
      repeat (n * TICK + extra) @(posedge sys_clk_i);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      {arst_n_i, psel, penable, pwrite, alarm_i, in_over_i, in_under_i, in_fault_i} = 8'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      seed = 32'h4EFD;
      repeat (2) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      // Reset state, readback, refused places
      secs(0, 4);
      note("lit_rst", 32'h1F, 32'h1F, 0); // reset lit
      apb(12'h000, 0, 0);
      note("ctrl_rst", 0, 32'hFFFFFFFF, 1); // reset value
      apb(12'h008, 1, 32'h77);
      note("bad_wr_err", 1, 1, 1);
      apb(12'h008, 0, 0);
      note("bad_rd", 0, 32'hFFFFFFFF, 1);
      apb(12'h004, 1, 32'h0);
      note("stat_wr_err", 0, 1, 1);
      $display("test regs done");
      // Each delay code blanks after its idle time; a key undoes it
      foreach (dly[i]) begin
         apb(12'h000, 1, i + 1);
         push_key();
         secs(dly[i], -12);
         note("pre_blank", 32'h1F, 32'h1F, 0); // still lit
         secs(0, 24);
         note("auto_blank", 32'h02, 32'h1E, 0); // dark
         apb(12'h004, 0, 0);
         note("stat_idle", (dly[i] << 16) | 1, 32'h01FF_0001, 1); // idle time
         b0 = blinks;
         secs(2, 0);
         rd_q = {31'h0, (blinks - b0) > 8'h02};
         note("blink", 1, 1, 1); // lamp blinks
         push_key();
         secs(0, 8);
         note("key_lit", 32'h1F, 32'h1F, 0); // key relights
      end
      apb(12'h000, 1, 0);
      push_key();
      secs(20, 0);
      note("off_lit", 32'h1F, 32'h1F, 0); // off stays lit
      $display("test auto done");
      // Each fault source relights and holds off blanking
      apb(12'h000, 1, 1);
      for (int f = 0; f < 4; f++) begin
         push_key();
         secs(16, 0);
         note("dark", 0, 32'h18, 0); // idle dark
         {alarm_i, in_over_i, in_under_i, in_fault_i} <= 4'h1 << f;
         secs(0, 8);
         note("err_lit", 32'h18, 32'h18, 0); // fault relights
         apb(12'h004, 0, 0);
         note("err_src", (f == 3) ? 32'h8 : 32'h4, 32'hC, 1); // error or alarm
         secs(20, 0);
         note("err_hold", 32'h18, 32'h18, 0); // no blanking
         {alarm_i, in_over_i, in_under_i, in_fault_i} <= 4'h0;
      end
      $display("test fault done");
      // Selector picks blanked items; upper half relights on a key
      for (s = 0; s < 9; s++) begin
         apb(12'h000, 1, s << 4);
         secs(0, 8);
         note("sel_mask", sel_exp[s], 32'h1F, 0); // masks
      end
      for (int r = 0; r < 3; r++) begin
         s = 5 + $unsigned($random(seed)) % 4;
         apb(12'h000, 1, s << 4);
         push_key();
         secs(4, 0);
         note("relit", 32'h1F, 32'h1F, 0); // window lit
         secs(1, 12);
         note("dark_again", sel_exp[s], 32'h1F, 0); // window ends
      end
      apb(12'h000, 1, 32'h80);
      push_key();
      in_fault_i <= 1'b1;
      secs(7, 0);
      note("relit_hold", 32'h1F, 32'h1F, 0); // fault holds
      apb(12'h004, 0, 0);
      note("relight_held", 32'h2, 32'h2, 1); // window held
      in_fault_i <= 1'b0;
      secs(0, 8);
      note("dark_after", 0, 32'h1F, 0); // then dark
      $display("test manual done");
      secs(0, 4);
      results();
   end
endmodule // testbench
